// [bench/pvr_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module pvr_assertions (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Management link.
  input wire logic mdc,
  input wire logic ctrl_o,
  input wire logic ctrl_oe,
  input wire logic dev_o,
  input wire logic dev_oe
);
  // ****************************
  // Link checks, sized for a half period of two cycles.
  // ****************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_mdc_high_len: assert property ($rose(mdc) |-> mdc[*2] ##1 !mdc)
    else $error("mdc high phase length wrong");
  a_no_contend: assert property (dev_oe |-> !ctrl_oe)
    else $error("both ends drive the wire");
  a_dev_turn_zero: assert property ($rose(dev_oe) |-> mdc && !dev_o)
    else $error("device turnaround bit wrong");
  a_dev_hold: assert property ($rose(dev_oe) |-> dev_oe[*8])
    else $error("device drive too short");
  a_dev_release: assert property ($rose(dev_oe) |-> ##[60:76] !dev_oe)
    else $error("device drive not released in time");
  a_dev_low_stable: assert property (dev_oe && !mdc && $past(dev_oe) |-> $stable(dev_o))
    else $error("device data moved in low phase");
  a_ctrl_low_chg: assert property (ctrl_oe && $past(ctrl_oe) && $changed(ctrl_o) |-> !mdc)
    else $error("controller data moved in high phase");
  a_ctrl_off_read: assert property ($rose(dev_oe) |-> !$past(ctrl_oe, 3))
    else $error("controller not released before turnaround");
endmodule
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top;
  import pvr_pkg::*;
  // ****************************
  // Signals and design.
  // ****************************
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, rd;
  logic [4:0]    addr_strap;
  logic [3:0]    autoneg_mode;
  pvr_an_state_t autoneg_state;
  logic          autoneg_done, cable_polarity_reversed_in, speed_is_10, full_duplex;
  logic          link_pulse_tx, force_good_link, heartbeat_active, squelch_normal, jabber_detect_enable;
  int            error_cnt, samples_checked, i;
  wire  [4:0]    outs = {link_pulse_tx, force_good_link, heartbeat_active, squelch_normal, jabber_detect_enable};

  pvr_mgmt_if mgmt_bus();
  pvr_mgmt_ctrl #(.HALF_CYC(2)) pvr_mgmt_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq, .mgmt(mgmt_bus));
  pvr_phy_regs pvr_phy_regs_i (.pclk, .presetn, .mgmt(mgmt_bus), .addr_strap, .autoneg_done,
    .autoneg_mode, .autoneg_state, .cable_polarity_reversed_in, .speed_is_10, .full_duplex,
    .link_pulse_tx, .force_good_link, .heartbeat_active, .squelch_normal, .jabber_detect_enable);
  pvr_assertions pvr_assertions_i (.pclk, .presetn, .mdc(mgmt_bus.mdc), .ctrl_o(mgmt_bus.ctrl_o),
    .ctrl_oe(mgmt_bus.ctrl_oe), .dev_o(mgmt_bus.dev_o), .dev_oe(mgmt_bus.dev_oe));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic give_verdict();
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************
  // Bus cycles. The wait is bounded even though the slave answers at once.
  // ****************************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (int n = 0; pready !== 1'b1; n++) begin
      if (n > 20) begin error_cnt++; give_verdict(); end
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wait_irq();
    for (int n = 0; irq !== 1'b1; n++) begin
      if (n > 2000) begin error_cnt++; give_verdict(); end
      @(posedge pclk);
    end
  endtask

  task automatic frame(input logic [10:0] cmd);
    apb(1'b1, PVR_APB_CMD, {21'h0, cmd});
    wait_irq();
    apb(1'b1, PVR_APB_IRQ_STAT, 32'h1);
    apb(1'b0, PVR_APB_STAT, 32'h0);
  endtask

  task automatic rd_reg(input logic [4:0] phy, input logic [4:0] r, input logic [15:0] e);
    frame({1'b0, phy, r});
    `CHK(rd[16:0], {1'b0, e})
  endtask

  task automatic wr_reg(input logic [4:0] phy, input logic [4:0] r, input logic [15:0] d);
    apb(1'b1, PVR_APB_WDATA, {16'h0, d});
    frame({1'b1, phy, r});
  endtask

  // ****************************
  // Main sequence.
  // ****************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata, autoneg_done, cable_polarity_reversed_in, full_duplex} = '0;
    {presetn, error_cnt, samples_checked} = '0;
    addr_strap = 5'h0b;
    autoneg_mode = 4'h4;
    autoneg_state = PVR_AN_IDLE;
    speed_is_10 = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK(outs, 5'h17)
    apb(1'b1, PVR_APB_IRQ_MASK, 32'h1);
    apb(1'b0, PVR_APB_IRQ_MASK, 32'h0);
    `CHK(rd, 32'h1)
    apb(1'b0, 12'h020, 32'h0);
    `CHK(err, 1'b1)
    rd_reg(5'h0b, 5'h11, 16'hf0b0);
    rd_reg(5'h0b, 5'h12, 16'h7800);
    for (i = 0; i < 8; i++) begin
      autoneg_state <= pvr_an_state_t'(i[3:0]);
      rd_reg(5'h0b, 5'h11, {4'hf, 3'h0, 5'h0b, i[3:0]});
    end
    autoneg_done <= 1'b1;
    cable_polarity_reversed_in <= 1'b1;
    @(posedge pclk);
    autoneg_done <= 1'b0;
    wr_reg(5'h0b, 5'h11, 16'h0f0f);
    rd_reg(5'h01, 5'h11, 16'hffff);
    rd_reg(5'h10, 5'h11, 16'h4107);
    wr_reg(5'h10, 5'h12, 16'hfbff);
    rd_reg(5'h10, 5'h12, 16'h7801);
    `CHK(outs, 5'h17)
    full_duplex <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK(outs, 5'h13)
    full_duplex <= 1'b0;
    wr_reg(5'h10, 5'h12, 16'h0000);
    `CHK(outs, 5'h08)
    speed_is_10 <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK(outs, 5'h00)
    // A command issued while busy is refused but only raises a masked event.
    apb(1'b1, PVR_APB_CMD, {21'h0, 1'b0, 5'h10, 5'h12});
    apb(1'b1, PVR_APB_CMD, 32'h0);
    apb(1'b0, PVR_APB_STAT, 32'h0);
    `CHK(rd[16], 1'b1)
    wait_irq();
    apb(1'b0, PVR_APB_IRQ_STAT, 32'h0);
    `CHK(rd[1:0], 2'h3)
    apb(1'b1, PVR_APB_IRQ_STAT, 32'h1);
    @(posedge pclk);
    `CHK(irq, 1'b0)
    apb(1'b1, PVR_APB_IRQ_STAT, 32'h2);
    apb(1'b0, PVR_APB_IRQ_STAT, 32'h0);
    `CHK(rd[1:0], 2'h0)
    give_verdict();
  end
endmodule
`default_nettype wire

// [design/pvr_mgmt_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
module pvr_mgmt_ctrl
  import pvr_pkg::*;
#(
  parameter int unsigned HALF_CYC = PVR_MDC_HALF_CYC
) (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt.
  output logic             irq,
  // Management link.
  pvr_mgmt_if.ctrl         mgmt
);

  typedef enum {
    PVR_C_IDLE,
    PVR_C_RUN
  } pvr_ctrl_state_t;

  localparam int unsigned DW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;

  pvr_ctrl_state_t           state;
  logic [DW-1:0]             div_cnt;
  logic                      mdc;
  logic [5:0]                bit_idx;
  logic [63:0]               frame;
  logic                      is_read;
  logic [15:0]               wdata;
  logic [15:0]               rdata;
  logic [PVR_IRQ_BITS-1:0]   irq_stat;
  logic [PVR_IRQ_BITS-1:0]   irq_mask;
  logic                      wr_acc;
  logic                      cmd_wr;
  logic                      half_end;
  logic                      done_ev;
  logic                      refused_ev;
  logic [PVR_IRQ_BITS-1:0]   next_irq_stat;

  // ************************************************************
  // APB decode; the slave always answers in the first access cycle.
  // ************************************************************
  assign pready  = 1'b1;
  assign wr_acc  = psel & penable & pwrite;
  assign cmd_wr  = wr_acc && (paddr == PVR_APB_CMD);
  assign pslverr = psel & penable & (paddr != PVR_APB_CMD) & (paddr != PVR_APB_WDATA) &
                   (paddr != PVR_APB_STAT) & (paddr != PVR_APB_IRQ_STAT) & (paddr != PVR_APB_IRQ_MASK);

  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      PVR_APB_WDATA:    prdata[15:0] = wdata;
      PVR_APB_STAT:     prdata = {15'h0000, (state == PVR_C_RUN), rdata};
      PVR_APB_IRQ_STAT: prdata[PVR_IRQ_BITS-1:0] = irq_stat;
      PVR_APB_IRQ_MASK: prdata[PVR_IRQ_BITS-1:0] = irq_mask;
      default:          prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdata    <= 16'h0000;
      irq_mask <= '0;
    end else if (wr_acc) begin
      if (paddr == PVR_APB_WDATA) begin
        wdata <= pwdata[15:0];
      end
      if (paddr == PVR_APB_IRQ_MASK) begin
        irq_mask <= pwdata[PVR_IRQ_BITS-1:0];
      end
    end
  end

  // ************************************************************
  // Interrupts. A new event wins over a clear in the same cycle.
  // ************************************************************
  assign done_ev    = (state == PVR_C_RUN) && half_end && mdc && (bit_idx == PVR_LAST_BIT);
  assign refused_ev = cmd_wr && (state == PVR_C_RUN);

  always_comb begin
    next_irq_stat = irq_stat;
    if (wr_acc && (paddr == PVR_APB_IRQ_STAT)) begin
      next_irq_stat = irq_stat & ~pwdata[PVR_IRQ_BITS-1:0];
    end
    next_irq_stat[PVR_IRQ_DONE]    = next_irq_stat[PVR_IRQ_DONE] | done_ev;
    next_irq_stat[PVR_IRQ_REFUSED] = next_irq_stat[PVR_IRQ_REFUSED] | refused_ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
      irq      <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq      <= |(next_irq_stat & irq_mask);
    end
  end

  // ************************************************************
  // Frame engine. Output bits change at the clock's falling half,
  // read data is sampled at its rising half.
  // ************************************************************
  assign half_end = (div_cnt == DW'(HALF_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= PVR_C_IDLE;
      div_cnt <= '0;
      mdc     <= 1'b0;
      bit_idx <= 6'd0;
      frame   <= '1;
      is_read <= 1'b0;
      rdata   <= 16'h0000;
    end else begin
      case (state)
        PVR_C_IDLE: begin
          if (cmd_wr) begin
            state   <= PVR_C_RUN;
            div_cnt <= '0;
            bit_idx <= 6'd0;
            is_read <= ~pwdata[PVR_CMD_WRITE];
            // The address goes out MSB first so bit 4 leads.
            frame   <= {{PVR_PREAMBLE_BITS{1'b1}}, PVR_START,
                        pwdata[PVR_CMD_WRITE] ? PVR_OP_WRITE : PVR_OP_READ,
                        pwdata[PVR_CMD_PHY_LSB +: 5], pwdata[4:0],
                        pwdata[PVR_CMD_WRITE] ? PVR_TA_WRITE : PVR_TA_READ,
                        pwdata[PVR_CMD_WRITE] ? wdata : 16'hffff};
          end
        end
        PVR_C_RUN: begin
          div_cnt <= half_end ? '0 : div_cnt + DW'(1);
          if (half_end) begin
            mdc <= ~mdc;
            if (!mdc) begin
              if (is_read && (bit_idx >= PVR_DATA_BIT)) begin
                rdata <= {rdata[14:0], mgmt.mdio};
              end
            end else if (bit_idx == PVR_LAST_BIT) begin
              state <= PVR_C_IDLE;
              frame <= '1;
            end else begin
              bit_idx <= bit_idx + 6'd1;
              frame   <= {frame[62:0], 1'b1};
            end
          end
        end
        default: begin
          state <= PVR_C_IDLE;
        end
      endcase
    end
  end

  assign mgmt.mdc     = mdc;
  assign mgmt.ctrl_o  = frame[63];
  assign mgmt.ctrl_oe = (state == PVR_C_RUN) && !(is_read && (bit_idx >= PVR_TA_BIT));

endmodule
`default_nettype wire

// [design/pvr_mgmt_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface pvr_mgmt_if;
  logic mdc;
  logic ctrl_o;
  logic ctrl_oe;
  logic dev_o;
  logic dev_oe;
  logic mdio;

  // Open-drain wire with pull-up: any enabled driver may pull it low.
  assign mdio = (ctrl_oe ? ctrl_o : 1'b1) & (dev_oe ? dev_o : 1'b1);

  modport ctrl (output mdc, output ctrl_o, output ctrl_oe, input mdio);
  modport dev  (input mdc, output dev_o, output dev_oe, input mdio);
endinterface
`default_nettype wire

// [design/pvr_phy_regs.sv]
`timescale 1ns/10ps
`default_nettype none
module pvr_phy_regs
  import pvr_pkg::*;
(
  // Clock and reset.
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Management link.
  pvr_mgmt_if.dev            mgmt,
  // Address strap.
  input  wire logic [4:0]    addr_strap,
  // Autonegotiation and 10BASE-T status.
  input  wire logic          autoneg_done,
  input  wire logic [3:0]    autoneg_mode,
  input  wire pvr_an_state_t autoneg_state,
  input  wire logic          cable_polarity_reversed_in,
  input  wire logic          speed_is_10,
  input  wire logic          full_duplex,
  // 10BASE-T controls.
  output logic               link_pulse_tx,
  output logic               force_good_link,
  output logic               heartbeat_active,
  output logic               squelch_normal,
  output logic               jabber_detect_enable
);

  typedef enum {
    PVR_D_IDLE,
    PVR_D_START,
    PVR_D_HDR,
    PVR_D_TA,
    PVR_D_RDATA,
    PVR_D_WDATA
  } pvr_dev_state_t;

  // ************************************************************
  // Register contents.
  // ************************************************************
  logic [3:0]    resolved_mode;
  pvr_an_state_t autoneg_debug_state;
  logic [4:0]    mgmt_station_address;
  logic          strap_taken;
  logic          link_pulse_enable;
  logic          heartbeat_enable;
  logic          squelch_sel;
  logic          jabber_en;
  logic          tbt_reserved;
  logic          cable_polarity_reversed;

  // ************************************************************
  // Link state.
  // ************************************************************
  pvr_dev_state_t state;
  logic           mdc_q;
  logic           mdc_rise;
  logic [5:0]     pre_cnt;
  logic [3:0]     bit_cnt;
  logic [1:0]     op;
  logic [4:0]     phy_sel;
  logic [4:0]     reg_sel;
  logic           hit;
  logic           wr_commit;
  logic [15:0]    wr_val;
  logic [15:0]    sh_q;
  logic [15:0]    rd_val;
  logic           sh_load;
  logic           sh_shift;
  logic           drv_o;
  logic           drv_oe;

  assign mdc_rise = mgmt.mdc & ~mdc_q;
  assign hit      = (sh_q[9:5] == mgmt_station_address) &&
                    ((sh_q[4:0] == PVR_REG_VENDOR_CFG) || (sh_q[4:0] == PVR_REG_10BT_CFG));
  assign wr_val   = {sh_q[14:0], mgmt.mdio};
  assign wr_commit = mdc_rise && (state == PVR_D_WDATA) && (bit_cnt == 4'hf) &&
                     (op == PVR_OP_WRITE) && (phy_sel == mgmt_station_address);

  always_comb begin
    rd_val = 16'h0000;
    if (reg_sel == PVR_REG_VENDOR_CFG) begin
      rd_val[PVR_VCS_MODE_LSB +: 4] = resolved_mode;
      rd_val[PVR_VCS_ADDR_LSB +: 5] = mgmt_station_address;
      rd_val[PVR_VCS_DBG_LSB +: 4]  = autoneg_debug_state;
    end else if (reg_sel == PVR_REG_10BT_CFG) begin
      rd_val[PVR_TBT_LPE] = link_pulse_enable;
      rd_val[PVR_TBT_HBE] = heartbeat_enable;
      rd_val[PVR_TBT_SQ]  = squelch_sel;
      rd_val[PVR_TBT_JAB] = jabber_en;
      rd_val[PVR_TBT_RSV] = tbt_reserved;
      rd_val[PVR_TBT_POL] = cable_polarity_reversed;
    end
  end

  // ************************************************************
  // Status capture.
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resolved_mode <= PVR_MODE_RST;
    end else if (autoneg_done) begin
      resolved_mode <= autoneg_mode;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      autoneg_debug_state     <= PVR_AN_IDLE;
      cable_polarity_reversed <= 1'b0;
    end else begin
      autoneg_debug_state     <= autoneg_state;
      cable_polarity_reversed <= cable_polarity_reversed_in;
    end
  end

  // ************************************************************
  // Station address, loaded from the strap after reset release.
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_taken          <= 1'b0;
      mgmt_station_address <= PVR_ADDR_RST;
    end else if (!strap_taken) begin
      strap_taken          <= 1'b1;
      mgmt_station_address <= addr_strap;
    end else if (wr_commit && (reg_sel == PVR_REG_VENDOR_CFG)) begin
      mgmt_station_address <= wr_val[PVR_VCS_ADDR_LSB +: 5];
    end
  end

  // ************************************************************
  // 10BASE-T configuration.
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_pulse_enable <= PVR_TBT_EN_RST;
      heartbeat_enable  <= PVR_TBT_EN_RST;
      squelch_sel       <= PVR_TBT_EN_RST;
      jabber_en         <= PVR_TBT_EN_RST;
      tbt_reserved      <= 1'b0;
    end else if (wr_commit && (reg_sel == PVR_REG_10BT_CFG)) begin
      link_pulse_enable <= wr_val[PVR_TBT_LPE];
      heartbeat_enable  <= wr_val[PVR_TBT_HBE];
      squelch_sel       <= wr_val[PVR_TBT_SQ];
      jabber_en         <= wr_val[PVR_TBT_JAB];
      tbt_reserved      <= wr_val[PVR_TBT_RSV];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_pulse_tx        <= 1'b0;
      force_good_link      <= 1'b0;
      heartbeat_active     <= 1'b0;
      squelch_normal       <= 1'b1;
      jabber_detect_enable <= 1'b1;
    end else begin
      link_pulse_tx        <= speed_is_10 & link_pulse_enable;
      force_good_link      <= speed_is_10 & ~link_pulse_enable;
      heartbeat_active     <= speed_is_10 & heartbeat_enable & ~full_duplex;
      squelch_normal       <= squelch_sel;
      jabber_detect_enable <= jabber_en;
    end
  end

  // ************************************************************
  // Management frame receiver and responder.
  // ************************************************************
  pvr_shift #(
    .WIDTH(PVR_DATA_BITS)
  ) u_shift (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (sh_load),
    .load_val (rd_val),
    .shift    (sh_shift),
    .sin      (mgmt.mdio),
    .q        (sh_q)
  );

  assign sh_load  = mdc_rise && (state == PVR_D_TA) && (bit_cnt == 4'h1);
  assign sh_shift = mdc_rise && ((state == PVR_D_HDR) || (state == PVR_D_RDATA) || (state == PVR_D_WDATA));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mdc_q <= 1'b0;
    end else begin
      mdc_q <= mgmt.mdc;
    end
  end

  // The header is taken at the first turnaround bit, when all twelve bits have arrived.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op      <= 2'b00;
      phy_sel <= 5'h00;
      reg_sel <= 5'h00;
    end else if (mdc_rise && (state == PVR_D_TA) && (bit_cnt == 4'h0)) begin
      op      <= sh_q[11:10];
      phy_sel <= sh_q[9:5];
      reg_sel <= sh_q[4:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= PVR_D_IDLE;
      pre_cnt <= 6'd0;
      bit_cnt <= 4'h0;
      drv_o   <= 1'b1;
      drv_oe  <= 1'b0;
    end else if (mdc_rise) begin
      case (state)
        PVR_D_IDLE: begin
          if (mgmt.mdio) begin
            if (pre_cnt != 6'(PVR_PREAMBLE_BITS)) begin
              pre_cnt <= pre_cnt + 6'd1;
            end
          end else begin
            pre_cnt <= 6'd0;
            if (pre_cnt == 6'(PVR_PREAMBLE_BITS)) begin
              state <= PVR_D_START;
            end
          end
        end
        PVR_D_START: begin
          bit_cnt <= 4'h0;
          state   <= mgmt.mdio ? PVR_D_HDR : PVR_D_IDLE;
        end
        PVR_D_HDR: begin
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == 4'(PVR_HDR_BITS - 1)) begin
            bit_cnt <= 4'h0;
            state   <= PVR_D_TA;
          end
        end
        PVR_D_TA: begin
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == 4'h0) begin
            // Only a read addressed to this device drives the second turnaround bit low.
            if ((sh_q[11:10] == PVR_OP_READ) && hit) begin
              drv_o  <= 1'b0;
              drv_oe <= 1'b1;
            end
          end else begin
            bit_cnt <= 4'h0;
            drv_o   <= rd_val[15];
            state   <= (op == PVR_OP_READ) ? PVR_D_RDATA : PVR_D_WDATA;
          end
        end
        PVR_D_RDATA: begin
          bit_cnt <= bit_cnt + 4'h1;
          drv_o   <= sh_q[14];
          if (bit_cnt == 4'hf) begin
            drv_oe <= 1'b0;
            drv_o  <= 1'b1;
            state  <= PVR_D_IDLE;
          end
        end
        PVR_D_WDATA: begin
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == 4'hf) begin
            state <= PVR_D_IDLE;
          end
        end
        default: begin
          state  <= PVR_D_IDLE;
          drv_oe <= 1'b0;
        end
      endcase
    end
  end

  assign mgmt.dev_o  = drv_o;
  assign mgmt.dev_oe = drv_oe;

endmodule
`default_nettype wire

// [design/pvr_pkg.sv]
`default_nettype none
// Functional notes
// - Latch one-hot resolved mode on autonegotiation done.
// - Software ignores mode bits outside autonegotiation.
// - Reserved bits read zero, writes ignored. Reserved bit ten of 10BASE-T config is stored on write and read back.
// - Address travels on link MSB first.
// - Controller uses correct address per access.
// - Debug state bits read-only, reset zero.
// - Debug codes four to seven as listed.
// - Link pulse enable, else force good link.
// - Heartbeat enable bit, 10 Mbps only.
// - Heartbeat ignored in full duplex.
// - Squelch select, normal when set.
// - Jabber detection enable bit, reset one.
// - Software writes zero to bit ten.
// - Polarity reversed flag follows 10BASE-T logic.
package pvr_pkg;

  // ************************************************************
  // Clock and management link timing.
  // ************************************************************
  localparam int unsigned PVR_CLK_PERIOD_NS = 8;
  localparam int unsigned PVR_MDC_PERIOD_NS = 400;
  localparam int unsigned PVR_MDC_HALF_CYC  = ((PVR_MDC_PERIOD_NS / 2) + PVR_CLK_PERIOD_NS - 1) / PVR_CLK_PERIOD_NS;

  // ************************************************************
  // Management frame layout, in bit times from the first preamble bit.
  // ************************************************************
  localparam int unsigned PVR_PREAMBLE_BITS = 32;
  localparam int unsigned PVR_HDR_BITS      = 12;
  localparam int unsigned PVR_DATA_BITS     = 16;
  localparam logic [5:0]  PVR_TA_BIT        = 6'd46;
  localparam logic [5:0]  PVR_DATA_BIT      = 6'd48;
  localparam logic [5:0]  PVR_LAST_BIT      = 6'd63;
  localparam logic [1:0]  PVR_START         = 2'b01;
  localparam logic [1:0]  PVR_OP_READ       = 2'b10;
  localparam logic [1:0]  PVR_OP_WRITE      = 2'b01;
  localparam logic [1:0]  PVR_TA_WRITE      = 2'b10;
  localparam logic [1:0]  PVR_TA_READ       = 2'b11;

  // ************************************************************
  // Device registers and fields.
  // ************************************************************
  localparam logic [4:0]  PVR_REG_VENDOR_CFG = 5'h11;
  localparam logic [4:0]  PVR_REG_10BT_CFG   = 5'h12;
  localparam int unsigned PVR_VCS_MODE_LSB   = 12;
  localparam int unsigned PVR_VCS_ADDR_LSB   = 4;
  localparam int unsigned PVR_VCS_DBG_LSB    = 0;
  localparam int unsigned PVR_TBT_LPE        = 14;
  localparam int unsigned PVR_TBT_HBE        = 13;
  localparam int unsigned PVR_TBT_SQ         = 12;
  localparam int unsigned PVR_TBT_JAB        = 11;
  localparam int unsigned PVR_TBT_RSV        = 10;
  localparam int unsigned PVR_TBT_POL        = 0;
  localparam logic [3:0]  PVR_MODE_RST       = 4'hf;
  localparam logic        PVR_TBT_EN_RST     = 1'b1;
  localparam logic [4:0]  PVR_ADDR_RST       = 5'h00;

  typedef enum logic [3:0] {
    PVR_AN_IDLE       = 4'h0,
    PVR_AN_ABIL_MATCH = 4'h1,
    PVR_AN_ACK_MATCH  = 4'h2,
    PVR_AN_ACK_FAIL   = 4'h3,
    PVR_AN_CONS_MATCH = 4'h4,
    PVR_AN_CONS_FAIL  = 4'h5,
    PVR_AN_PD_READY   = 4'h6,
    PVR_AN_PD_FAIL    = 4'h7
  } pvr_an_state_t;

  // ************************************************************
  // Controller register map on APB.
  // ************************************************************
  localparam logic [11:0] PVR_APB_CMD      = 12'h000;
  localparam logic [11:0] PVR_APB_WDATA    = 12'h004;
  localparam logic [11:0] PVR_APB_STAT     = 12'h008;
  localparam logic [11:0] PVR_APB_IRQ_STAT = 12'h00c;
  localparam logic [11:0] PVR_APB_IRQ_MASK = 12'h010;
  localparam int unsigned PVR_CMD_PHY_LSB  = 5;
  localparam int unsigned PVR_CMD_WRITE    = 10;
  localparam int unsigned PVR_STAT_BUSY    = 16;
  localparam int unsigned PVR_IRQ_DONE     = 0;
  localparam int unsigned PVR_IRQ_REFUSED  = 1;
  localparam int unsigned PVR_IRQ_BITS     = 2;

endpackage
`default_nettype wire

// [design/pvr_shift.sv]
`timescale 1ns/10ps
`default_nettype none
module pvr_shift #(
  parameter int unsigned WIDTH = 16
) (
  // Clock and reset.
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Control.
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_val,
  input  wire logic             shift,
  input  wire logic             sin,
  // State.
  output logic      [WIDTH-1:0] q
);

  // Shifts toward the MSB so the first bit on the wire is the most significant.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else if (load) begin
      q <= load_val;
    end else if (shift) begin
      q <= {q[WIDTH-2:0], sin};
    end
  end

endmodule
`default_nettype wire
